// ### core/smc_defs.vh
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH

// Register byte offsets on the AXI4-Lite slave.
`define SMC_OFF_STATUS     8'h00
`define SMC_OFF_CONFIG     8'h04
`define SMC_OFF_IRQ_STAT   8'h08
`define SMC_OFF_IRQ_MASK   8'h0C

// Status register fields.
`define SMC_ST_LOW_BIT     0
`define SMC_ST_RANGE_BIT   1
`define SMC_ST_LOCK_BIT    2
`define SMC_ST_ACTIVE_BIT  3
`define SMC_ST_RSTREQ_BIT  4

// Configuration register fields.
`define SMC_CF_PWRD_BIT    0
`define SMC_CF_RSTD_BIT    1
`define SMC_CF_STOPEN_BIT  2
`define SMC_CF_RANGE_BIT   3
`define SMC_CF_MASK        8'h0F

// Event status fields.
`define SMC_EV_FALL_BIT    0
`define SMC_EV_RISE_BIT    1
`define SMC_EV_RST_BIT     2
`define SMC_EV_WIDTH       3

// Reset values.
`define SMC_CONFIG_RST     8'h00
`define SMC_MASK_RST       3'h0

// AXI responses.
`define SMC_RESP_OKAY      2'h0
`define SMC_RESP_SLVERR    2'h2

`endif

// ### core/smc_sync2.v
`include "smc_defs.vh"

module smc_sync2
(
   aclk,
   aresetn,
   d,
   q
);
   input  wire aclk;
   input  wire aresetn;
   input  wire d;
   output wire q;

   reg s1_ff;
   reg s2_ff;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= d;
         s2_ff <= s1_ff;
      end
   end

   assign q = s2_ff;
endmodule // smc_sync2

// ### core/smc_hyst.v
`include "smc_defs.vh"

// Hysteretic flag: set below the falling level, clear above the rising level.
module smc_hyst
(
   aclk,
   aresetn,
   enable,
   below_fall,
   above_rise,
   flag
);
   input  wire aclk;
   input  wire aresetn;
   input  wire enable;
   input  wire below_fall;
   input  wire above_rise;
   output wire flag;

   reg flag_ff;
   reg nxt_flag;

   always @*
   begin
      nxt_flag = flag_ff;
      if (!enable)
         nxt_flag = 1'b0;
      else if (below_fall)
         nxt_flag = 1'b1;
      else if (above_rise)
         nxt_flag = 1'b0;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         flag_ff <= 1'b0;
      else
         flag_ff <= nxt_flag;
   end

   assign flag = flag_ff;
endmodule // smc_hyst

// ### core/smc_top.v
// Contract
// - Power-on reset clears the high range select, so the low range is used.
// - Setting high range select picks the higher falling trip range.
// - High range select is write-once; later changes are ignored.
// - After a monitor reset, hold reset until supply rises above rising level.
// - The supply monitor is enabled out of reset.
// - Power disable turns the supply monitor off entirely.
// - Reset disable blocks reset requests; the status flag still tracks.
// - With both disables clear, request reset when supply falls below falling level.
// - Read-only supply low flag follows the comparator for polling.
// - Flag is 1 below falling level, 0 above rising level, else held.
// - The supply monitor raises no interrupt requests; here irq is raised by unmasked low-flag and reset events.
// - Monitor stays active in wait mode and its reset ends wait.
// - In stop, active only with power disable clear and stop enable set.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`include "smc_defs.vh"

module smc_top
(
   aclk,
   aresetn,
   below_fall_trip,
   above_rise_trip,
   wait_mode,
   stop_mode,
   high_range_out,
   monitor_active,
   reset_request,
   irq,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready
);
   input  wire        aclk;
   input  wire        aresetn;
   input  wire        below_fall_trip;
   input  wire        above_rise_trip;
   input  wire        wait_mode;
   input  wire        stop_mode;
   output wire        high_range_out;
   output wire        monitor_active;
   output wire        reset_request;
   output wire        irq;
   input  wire [7:0]  s_axi_awaddr;
   input  wire        s_axi_awvalid;
   output wire        s_axi_awready;
   input  wire [31:0] s_axi_wdata;
   input  wire [3:0]  s_axi_wstrb;
   input  wire        s_axi_wvalid;
   output wire        s_axi_wready;
   output wire [1:0]  s_axi_bresp;
   output wire        s_axi_bvalid;
   input  wire        s_axi_bready;
   input  wire [7:0]  s_axi_araddr;
   input  wire        s_axi_arvalid;
   output wire        s_axi_arready;
   output wire [31:0] s_axi_rdata;
   output wire [1:0]  s_axi_rresp;
   output wire        s_axi_rvalid;
   input  wire        s_axi_rready;

   ////////////////////////////////////////////////////////////////////////////
   // Comparator synchronisers.

   wire fall_s;
   wire rise_s;

   smc_sync2 u_sync_fall
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (below_fall_trip),
      .q       (fall_s)
   );

   smc_sync2 u_sync_rise
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (above_rise_trip),
      .q       (rise_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state.

   reg        pwrd_ff;
   reg        rstd_ff;
   reg        stopen_ff;
   reg        range_ff;
   reg        locked_ff;
   reg        rst_hold_ff;
   reg        low_d_ff;
   reg [2:0]  ev_ff;
   reg [2:0]  mask_ff;

   reg        aw_ok_ff;
   reg [7:0]  aw_addr_ff;
   reg        w_ok_ff;
   reg [31:0] w_data_ff;
   reg [3:0]  w_strb_ff;
   reg        bvalid_ff;
   reg [1:0]  bresp_ff;
   reg        rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0]  rresp_ff;

   wire       low_flag;

   // Monitor runs unless powered down, and in stop only when stop enable is set.
   wire active = !pwrd_ff && !(stop_mode && !stopen_ff);

   smc_hyst u_hyst
   (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (active),
      .below_fall (fall_s),
      .above_rise (rise_s),
      .flag       (low_flag)
   );

   // Wait mode needs no gating: the monitor and its reset run as in run mode.
   wire trip_now = active && !rstd_ff && fall_s;

   ////////////////////////////////////////////////////////////////////////////
   // Reset request with hysteretic release.

   always @(posedge aclk)
   begin
      if (!aresetn)
         rst_hold_ff <= 1'b0;
      else if (trip_now)
         rst_hold_ff <= 1'b1;
      else if (rst_hold_ff && rise_s)
         rst_hold_ff <= 1'b0;
   end

   // Held reset survives a later reset disable write; only the rising level frees it.
   assign reset_request = rst_hold_ff;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path.

   wire aw_take = s_axi_awvalid && !aw_ok_ff && !bvalid_ff;
   wire w_take  = s_axi_wvalid && !w_ok_ff && !bvalid_ff;
   wire do_wr   = aw_ok_ff && w_ok_ff && !bvalid_ff;

   assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
   assign s_axi_wready  = !w_ok_ff && !bvalid_ff;

   wire wr_cfg  = do_wr && (aw_addr_ff == `SMC_OFF_CONFIG) && w_strb_ff[0];
   wire wr_ist  = do_wr && (aw_addr_ff == `SMC_OFF_IRQ_STAT) && w_strb_ff[0];
   wire wr_msk  = do_wr && (aw_addr_ff == `SMC_OFF_IRQ_MASK) && w_strb_ff[0];
   wire wr_map  = (aw_addr_ff == `SMC_OFF_STATUS) || (aw_addr_ff == `SMC_OFF_CONFIG)
                  || (aw_addr_ff == `SMC_OFF_IRQ_STAT) || (aw_addr_ff == `SMC_OFF_IRQ_MASK);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok_ff   <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_ok_ff    <= 1'b0;
         w_data_ff  <= 32'h00000000;
         w_strb_ff  <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `SMC_RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_ok_ff   <= 1'b1;
            aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_take)
         begin
            w_ok_ff   <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_ok_ff  <= 1'b0;
            w_ok_ff   <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_map ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
         end
         else if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register; range bit is write-once.

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pwrd_ff   <= 1'b0;
         rstd_ff   <= 1'b0;
         stopen_ff <= 1'b0;
         range_ff  <= 1'b0;
         locked_ff <= 1'b0;
      end
      else if (wr_cfg)
      begin
         pwrd_ff   <= w_data_ff[`SMC_CF_PWRD_BIT];
         rstd_ff   <= w_data_ff[`SMC_CF_RSTD_BIT];
         stopen_ff <= w_data_ff[`SMC_CF_STOPEN_BIT];
         locked_ff <= 1'b1;
         if (!locked_ff)
            range_ff <= w_data_ff[`SMC_CF_RANGE_BIT];
      end
   end

   assign high_range_out = range_ff;
   assign monitor_active = active;

   ////////////////////////////////////////////////////////////////////////////
   // Bus-side event status. The monitor itself raises nothing; these
   // are the block's own bus events, kept off unless software unmasks them.

   wire [2:0] ev_set;
   assign ev_set[`SMC_EV_FALL_BIT] = low_flag && !low_d_ff;
   assign ev_set[`SMC_EV_RISE_BIT] = !low_flag && low_d_ff;
   assign ev_set[`SMC_EV_RST_BIT]  = trip_now && !rst_hold_ff;

   genvar gi;
   generate
      for (gi = 0; gi < `SMC_EV_WIDTH; gi = gi + 1)
      begin : g_ev
         always @(posedge aclk)
         begin
            if (!aresetn)
               ev_ff[gi] <= 1'b0;
            else if (ev_set[gi])
               ev_ff[gi] <= 1'b1;
            else if (wr_ist && w_data_ff[gi])
               ev_ff[gi] <= 1'b0;
         end
      end
   endgenerate

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         low_d_ff <= 1'b0;
         mask_ff  <= `SMC_MASK_RST;
      end
      else
      begin
         low_d_ff <= low_flag;
         if (wr_msk)
            mask_ff <= w_data_ff[2:0];
      end
   end

   // Mask resets to zero, so nothing is requested unless software opts in.
   assign irq = |(ev_ff & mask_ff);

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path.

   reg [31:0] rd_mux;
   reg        rd_hit;

   always @*
   begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case ({s_axi_araddr[7:2], 2'b00})
         `SMC_OFF_STATUS:
         begin
            rd_mux[`SMC_ST_LOW_BIT]    = low_flag;
            rd_mux[`SMC_ST_RANGE_BIT]  = range_ff;
            rd_mux[`SMC_ST_LOCK_BIT]   = locked_ff;
            rd_mux[`SMC_ST_ACTIVE_BIT] = active;
            rd_mux[`SMC_ST_RSTREQ_BIT] = rst_hold_ff;
         end
         `SMC_OFF_CONFIG:
         begin
            rd_mux[`SMC_CF_PWRD_BIT]   = pwrd_ff;
            rd_mux[`SMC_CF_RSTD_BIT]   = rstd_ff;
            rd_mux[`SMC_CF_STOPEN_BIT] = stopen_ff;
            rd_mux[`SMC_CF_RANGE_BIT]  = range_ff;
         end
         `SMC_OFF_IRQ_STAT:
            rd_mux[2:0] = ev_ff;
         `SMC_OFF_IRQ_MASK:
            rd_mux[2:0] = mask_ff;
         default:
            rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = !rvalid_ff;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= `SMC_RESP_OKAY;
      end
      else if (s_axi_arvalid && !rvalid_ff)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_mux;
         rresp_ff  <= rd_hit ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
         rvalid_ff <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata  = rdata_ff;
   assign s_axi_rresp  = rresp_ff;
endmodule // smc_top

// ### sim/smc_supply_model.sv
module smc_supply_model
(
   input  wire logic [1:0] zone,
   output logic            below_fall_trip,
   output logic            above_rise_trip
);
   timeunit 1ns;
   timeprecision 1ps;

   // Zone 0 lies below the falling level, zone 2 above the rising level.
   // In the band between, both outputs stay low, so only the flag's own memory can hold it.
   assign below_fall_trip = (zone == 2'h0);
   assign above_rise_trip = (zone == 2'h2);
endmodule // smc_supply_model

// ### sim/smc_checker_monitor.sv
module smc_monitor
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic below_fall_trip,
   input wire logic above_rise_trip,
   input wire logic monitor_active,
   input wire logic reset_request,
   input wire logic high_range_out,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_req_after_fall: assert property ($rose(reset_request) |-> $past(below_fall_trip, 3))
      else $error("reset request rose without a synchronized low supply");
   a_req_until_rise: assert property ($fell(reset_request) |-> $past(above_rise_trip, 3))
      else $error("reset request dropped before the supply rose");
   a_idle_no_req: assert property (!monitor_active && !reset_request |=> !reset_request)
      else $error("inactive monitor raised a reset request");
   a_range_write_once: assert property (high_range_out |=> high_range_out)
      else $error("high range select was cleared after being set");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while a read is pending");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken while a response is pending");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held after handshake");
   a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data held after handshake");
endmodule // smc_monitor

bind smc_top smc_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .below_fall_trip(below_fall_trip),
   .above_rise_trip(above_rise_trip), .monitor_active(monitor_active), .reset_request(reset_request),
   .high_range_out(high_range_out), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ### sim/test_supply_monitor_control.sv
module test_supply_monitor_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn, wait_mode, stop_mode, below_fall_trip, above_rise_trip;
   logic        high_range_out, monitor_active, reset_request, irq;
   logic [1:0]  zone;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          n_errors = 0;
   int          n_compared = 0;
   int          cycles = 0;

   smc_top dut (.aclk, .aresetn, .below_fall_trip, .above_rise_trip, .wait_mode, .stop_mode,
      .high_range_out, .monitor_active, .reset_request, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   smc_supply_model u_supply (.zone, .below_fall_trip, .above_rise_trip);

   always #4 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // The whole run needs well under a thousand cycles, so this only catches a hung handshake.
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check("bresp", s_axi_bresp, er);
   endtask

   // Read data is compared only when an OKAY answer is expected; an error answer carries none.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check("rresp", s_axi_rresp, er);
      if (er == 2'h0) check("rdata", s_axi_rdata, exp);
   endtask

   // The comparator path has three edges of latency; six leave margin without hiding a stuck flop.
   task automatic set_zone(input logic [1:0] z);
      zone <= z;
      repeat (6) @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      aresetn = 1'b0;
      zone = 2'h2;
      wait_mode = 1'b0;
      stop_mode = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 32'h08, 2'h0);
      rd(8'h04, 32'h00, 2'h0);
      rd(8'h0C, 32'h00, 2'h0);
      rd(8'h10, 32'h00, 2'h2);
      check("high_range_out", high_range_out, 1'b0);
      $display("test reset values done");
      set_zone(2'h0);
      check("reset_request", reset_request, 1'b1);
      check("irq", irq, 1'b0);
      rd(8'h00, 32'h19, 2'h0);
      set_zone(2'h1);
      check("reset_request", reset_request, 1'b1);
      rd(8'h00, 32'h19, 2'h0);
      set_zone(2'h2);
      check("reset_request", reset_request, 1'b0);
      rd(8'h00, 32'h08, 2'h0);
      rd(8'h08, 32'h07, 2'h0);
      wr(8'h0C, 32'h01, 2'h0);
      check("irq", irq, 1'b1);
      wr(8'h0C, 32'h00, 2'h0);
      check("irq", irq, 1'b0);
      wr(8'h08, 32'h07, 2'h0);
      rd(8'h08, 32'h00, 2'h0);
      wr(8'h14, 32'h01, 2'h2);
      $display("test forced reset done");
      wr(8'h04, 32'h0A, 2'h0);
      check("high_range_out", high_range_out, 1'b1);
      set_zone(2'h0);
      check("reset_request", reset_request, 1'b0);
      rd(8'h00, 32'h0F, 2'h0);
      set_zone(2'h2);
      wr(8'h04, 32'h02, 2'h0);
      check("high_range_out", high_range_out, 1'b1);
      rd(8'h00, 32'h0E, 2'h0);
      $display("test polled mode done");
      wr(8'h04, 32'h01, 2'h0);
      check("monitor_active", monitor_active, 1'b0);
      set_zone(2'h0);
      check("reset_request", reset_request, 1'b0);
      rd(8'h00, 32'h06, 2'h0);
      set_zone(2'h2);
      $display("test power disable done");
      wr(8'h04, 32'h00, 2'h0);
      wait_mode <= 1'b1;
      set_zone(2'h0);
      check("monitor_active", monitor_active, 1'b1);
      check("reset_request", reset_request, 1'b1);
      set_zone(2'h2);
      wait_mode <= 1'b0;
      stop_mode <= 1'b1;
      @(posedge aclk);
      check("monitor_active", monitor_active, 1'b0);
      wr(8'h04, 32'h04, 2'h0);
      check("monitor_active", monitor_active, 1'b1);
      set_zone(2'h0);
      check("reset_request", reset_request, 1'b1);
      set_zone(2'h2);
      stop_mode <= 1'b0;
      $display("test low power modes done");
      // A second reset must drop the locked high range back to the low range.
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      check("high_range_out", high_range_out, 1'b0);
      rd(8'h04, 32'h00, 2'h0);
      rd(8'h00, 32'h08, 2'h0);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule // test_supply_monitor_control
